/* rtl/edm_pkg.sv */
/*
 * constants, types and decode helpers of the edit micro-op engine.
 * assumes a single 100 MHz clock and an avalon-mm register slave.
 */
// Contract
// - each 9-bit character of the micro-op string is one whole micro-op; load-entry and change-table take the chars after them as entries.
// - the move ends when the op, source or receiving length runs out.
// - fetching a load-entry or change-table entry char from a spent op string faults.
// - insertion characters sit in an eight-entry table of 9-bit chars.
// - each edit reloads the table with space * + - $ , . 0 in order.
// - load-entry and change-table ops overwrite one or all entries.
// - the suppression-ended flag starts clear and an op sets it.
// - with an alphanumeric source the negative flag starts clear.
// - with a numeric source the sign char sets or clears the negative flag.
// - the all-zero flag starts set and clears on a nonzero digit.
// - blank-on-zero starts clear; only end-float or set-end-supp set it.
// - all-zero with blank-on-zero at the end fills the field with entry 0.
// - alphanumeric moves convert among 9-bit, 6-bit and 4-bit chars.
// - numeric moves convert between ascii and packed digits.
// - sign type 00 lead float, 01 lead scaled, 10 trail, 11 none.
// - numeric type code 0 is ascii digits, 1 is packed digits.
package edm_pkg;

	// ****************************************************************
	// bus map
	// ****************************************************************
	localparam int unsigned AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_LEN  = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ  = 8'h0C;
	localparam logic [7:0] REG_MASK = 8'h10;
	localparam logic [1:0] RGN_REG  = 2'h0;
	localparam logic [1:0] RGN_MOP  = 2'h1;
	localparam logic [1:0] RGN_SRC  = 2'h2;
	localparam logic [1:0] RGN_DST  = 2'h3;
	localparam logic [1:0] RGN_TBL  = 2'h2;

	// ****************************************************************
	// fields
	// ****************************************************************
	localparam int unsigned CTRL_START  = 0;
	localparam int unsigned CTRL_NUM    = 1;
	localparam int unsigned CTRL_SGN_LO = 2;
	localparam int unsigned CTRL_STN    = 4;
	localparam int unsigned CTRL_DTN    = 5;
	localparam int unsigned CTRL_SCT_LO = 6;
	localparam int unsigned CTRL_DCT_LO = 8;
	localparam int unsigned LEN_MOP_LO  = 0;
	localparam int unsigned LEN_SRC_LO  = 8;
	localparam int unsigned LEN_DST_LO  = 16;
	localparam int unsigned IRQ_DONE    = 0;
	localparam int unsigned IRQ_FAULT   = 1;
	localparam int unsigned OP_LO       = 6;

	// ****************************************************************
	// sizes and characters
	// ****************************************************************
	localparam int unsigned LW = 5;
	localparam logic [4:0]  DEPTH    = 5'h10;
	localparam logic [4:0]  ONE      = 5'h01;
	localparam logic [4:0]  TBL_N    = 5'h08;
	localparam logic [8:0]  CH_ZERO  = 9'h030;
	localparam logic [8:0]  CH_MINUS = 9'h02D;
	localparam logic [3:0]  PK_NEG_A = 4'hD;
	localparam logic [3:0]  PK_NEG_B = 4'hB;
	localparam logic [3:0]  TEN      = 4'hA;
	localparam logic [4:0]  ASC_DIG  = 5'h03;
	localparam logic [7:0][8:0] TBL_INIT = {
		9'h030, 9'h02E, 9'h02C, 9'h024,
		9'h02D, 9'h02B, 9'h02A, 9'h020};

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		CT_ASCII = 2'b00,
		CT_SIX   = 2'b01,
		CT_PACK  = 2'b10,
		CT_BAD   = 2'b11
	} edm_ctype_t;

	typedef enum logic [1:0] {
		SG_LEAD_FLT = 2'b00,
		SG_LEAD_SCL = 2'b01,
		SG_TRAIL    = 2'b10,
		SG_NONE     = 2'b11
	} edm_sign_t;

	typedef enum logic [2:0] {
		OP_MOVE = 3'b000,
		OP_MOVZ = 3'b001,
		OP_INS  = 3'b010,
		OP_LTE  = 3'b011,
		OP_CHT  = 3'b100,
		OP_SES  = 3'b101,
		OP_ENF  = 3'b110,
		OP_SKIP = 3'b111
	} edm_op_t;

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	function automatic logic edm_lead(input edm_sign_t s);
		return (s == SG_LEAD_FLT) || (s == SG_LEAD_SCL);
	endfunction

	function automatic logic edm_is_neg(input logic [8:0] ch,
					    input logic pk);
		if (pk)
			return (ch[3:0] == PK_NEG_A) || (ch[3:0] == PK_NEG_B);
		return ch == CH_MINUS;
	endfunction

endpackage

/* rtl/edm_conv.sv */
/*
 * character converter between ascii, 6-bit and packed digit forms.
 * assumes one char per 9-bit slot, low bits used for narrow forms.
 */
`timescale 1ns/1ps
module edm_conv (
	// source character
	input  wire logic [8:0]        ch,
	input  wire edm_pkg::edm_ctype_t from_t,
	// target form
	input  wire edm_pkg::edm_ctype_t to_t,
	// results
	output logic      [8:0]        out,
	output logic                   is_zero
);
	import edm_pkg::*;

	logic asc_dig;

	always_comb begin
		asc_dig = ch[8:4] == ASC_DIG;
		is_zero = (from_t == CT_ASCII) ? (ch == CH_ZERO)
			: (ch[3:0] == 4'h0);
		out = ch;
		unique case (to_t)
		CT_ASCII: begin
			if (from_t != CT_ASCII && ch[5:0] < {2'b00, TEN})
				out = CH_ZERO + {5'h00, ch[3:0]};
			else if (from_t != CT_ASCII)
				out = {3'b000, ch[5:0]};
		end
		CT_SIX: begin
			// non-digit ascii keeps its low six bits
			out = (from_t == CT_ASCII && asc_dig)
				? {5'h00, ch[3:0]} : {3'b000, ch[5:0]};
		end
		default: out = {5'h00, ch[3:0]};
		endcase
	end

endmodule

/* rtl/edm_engine.sv */
/*
 * edit micro-op engine: alphanumeric and numeric edited moves.
 * assumes software fills op and source buffers over avalon-mm, then
 * starts the edit and collects the receiving field from its buffer.
 */
`timescale 1ns/1ps
module edm_engine (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	// avalon-mm slave
	input  wire logic [edm_pkg::AW-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	// status
	output logic                        irq,
	output logic                        busy
);
	import edm_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SIGN  = 3'b001,
		ST_FETCH = 3'b010,
		ST_EXEC  = 3'b011,
		ST_FILL  = 3'b100
	} edm_st_t;

	typedef struct packed {
		edm_st_t         st;
		logic            ack;
		logic [31:0]     rdata;
		logic            numeric;
		edm_sign_t       sgn;
		logic            stn;
		logic            dtn;
		edm_ctype_t      sct;
		edm_ctype_t      dct;
		logic [LW-1:0]   mlen;
		logic [LW-1:0]   slen;
		logic [LW-1:0]   dlen;
		logic [LW-1:0]   mi;
		logic [LW-1:0]   si;
		logic [LW-1:0]   send;
		logic [LW-1:0]   di;
		logic [LW-1:0]   cnt;
		edm_op_t         op;
		logic [5:0]      fld;
		logic            es;
		logic            neg;
		logic            zero;
		logic            bz;
		logic [1:0]      ists;
		logic [1:0]      mask;
		logic [7:0][8:0] tbl;
		logic [15:0][8:0] mop;
		logic [15:0][8:0] src;
		logic [15:0][8:0] dst;
	} edm_state_t;

	edm_state_t q;
	edm_state_t d;

	function automatic logic [LW-1:0] clamp(input logic [LW-1:0] v);
		return (v > DEPTH) ? DEPTH : v;
	endfunction

	// ****************************************************************
	// datapath helpers
	// ****************************************************************
	edm_ctype_t ef_src;
	edm_ctype_t ef_dst;
	logic [8:0] cv_out;
	logic       cv_zero;
	logic [8:0] s_ch;
	logic [8:0] m_ch;
	logic [1:0] rgn;
	logic [3:0] idx;
	logic [7:0] off;
	logic       s_out;
	logic       d_full;
	logic       m_out;

	always_comb begin
		ef_src = q.numeric ? (q.stn ? CT_PACK : CT_ASCII) : q.sct;
		ef_dst = q.numeric ? (q.dtn ? CT_PACK : CT_ASCII) : q.dct;
		s_ch   = q.src[q.si[3:0]];
		m_ch   = q.mop[q.mi[3:0]];
		rgn    = avs_address[7:6];
		idx    = avs_address[5:2];
		off    = {avs_address[7:2], 2'b00};
		s_out  = q.si >= q.send;
		d_full = q.di >= q.dlen;
		m_out  = q.mi >= q.mlen;
	end

	edm_conv u_conv (
		.ch      (s_ch),
		.from_t  (ef_src),
		.to_t    (ef_dst),
		.out     (cv_out),
		.is_zero (cv_zero)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		d.ack = 1'b0;

		// bus: one wait cycle, answer from flops
		if ((avs_read || avs_write) && !q.ack) begin
			d.ack = 1'b1;
			d.rdata = 32'h0000_0000;
			unique case (rgn)
			RGN_REG: begin
				if (avs_address[5])
					d.rdata = {23'h00_0000, q.tbl[idx[2:0]]};
				else if (off == REG_CTRL)
					d.rdata = {22'h00_0000, q.dct, q.sct,
						q.dtn, q.stn, q.sgn, q.numeric,
						1'b0};
				else if (off == REG_LEN)
					d.rdata = {11'h000, q.dlen, 3'b000,
						q.slen, 3'b000, q.mlen};
				else if (off == REG_STAT)
					d.rdata = {19'h0_0000, q.di, 3'b000,
						q.bz, q.zero, q.neg, q.es, busy};
				else if (off == REG_IRQ)
					d.rdata = {30'h0000_0000, q.ists};
				else if (off == REG_MASK)
					d.rdata = {30'h0000_0000, q.mask};
			end
			RGN_MOP: d.rdata = {23'h00_0000, q.mop[idx]};
			RGN_SRC: d.rdata = {23'h00_0000, q.src[idx]};
			RGN_DST: d.rdata = {23'h00_0000, q.dst[idx]};
			endcase
		end

		// bus writes land at the edge after the wait, the one that accepts the access
		if (q.ack && avs_write) begin
			if (rgn == RGN_REG && off == REG_IRQ)
				d.ists = q.ists & ~avs_writedata[1:0];
			else if (rgn == RGN_REG && off == REG_MASK)
				d.mask = avs_writedata[1:0];
			else if (q.st == ST_IDLE) begin
				// buffers and setup are frozen while busy
				if (rgn == RGN_MOP)
					d.mop[idx] = avs_writedata[8:0];
				else if (rgn == RGN_SRC)
					d.src[idx] = avs_writedata[8:0];
				else if (rgn == RGN_REG && off == REG_LEN) begin
					d.mlen = avs_writedata[LEN_MOP_LO +: LW];
					d.slen = avs_writedata[LEN_SRC_LO +: LW];
					d.dlen = avs_writedata[LEN_DST_LO +: LW];
				end else if (rgn == RGN_REG && off == REG_CTRL) begin
					d.numeric = avs_writedata[CTRL_NUM];
					d.sgn = edm_sign_t'(avs_writedata[CTRL_SGN_LO +: 2]);
					d.stn = avs_writedata[CTRL_STN];
					d.dtn = avs_writedata[CTRL_DTN];
					d.sct = edm_ctype_t'(avs_writedata[CTRL_SCT_LO +: 2]);
					d.dct = edm_ctype_t'(avs_writedata[CTRL_DCT_LO +: 2]);
					if (avs_writedata[CTRL_START]) begin
						d.tbl  = TBL_INIT;
						d.es   = 1'b0;
						d.neg  = 1'b0;
						d.zero = 1'b1;
						d.bz   = 1'b0;
						d.mi   = '0;
						d.si   = '0;
						d.di   = '0;
						d.mlen = clamp(q.mlen);
						d.slen = clamp(q.slen);
						d.dlen = clamp(q.dlen);
						d.send = clamp(q.slen);
						if (!d.numeric && (d.sct == CT_BAD ||
						    d.dct == CT_BAD))
							d.ists[IRQ_FAULT] = 1'b1;
						else
							d.st = d.numeric ? ST_SIGN
								: ST_FETCH;
					end
				end
			end
		end

		// engine
		unique case (q.st)
		ST_IDLE: ;
		ST_SIGN: begin
			if (q.sgn != SG_NONE && q.slen != '0) begin
				if (edm_lead(q.sgn)) begin
					d.neg = edm_is_neg(q.src[0], q.stn);
					d.si = ONE;
				end else begin
					d.neg = edm_is_neg(
						q.src[4'(q.slen - ONE)], q.stn);
					d.send = q.slen - ONE;
				end
			end
			d.st = ST_FETCH;
		end
		ST_FETCH: begin
			if (m_out || s_out || d_full) begin
				d.st = ST_FILL;
				d.di = '0;
			end else begin
				d.op  = edm_op_t'(m_ch[8:OP_LO]);
				d.fld = m_ch[OP_LO-1:0];
				d.mi  = q.mi + ONE;
				d.cnt = (m_ch[3:0] == 4'h0) ? DEPTH
					: {1'b0, m_ch[3:0]};
				if (edm_op_t'(m_ch[8:OP_LO]) == OP_CHT)
					d.cnt = TBL_N;
				d.st = ST_EXEC;
			end
		end
		ST_EXEC: begin
			unique case (q.op)
			OP_MOVE, OP_MOVZ: begin
				if (s_out || d_full) begin
					d.st = ST_FILL;
					d.di = '0;
				end else begin
					d.dst[q.di[3:0]] = (q.op == OP_MOVZ &&
						!q.es && cv_zero) ? q.tbl[0]
						: cv_out;
					if (!cv_zero)
						d.zero = 1'b0;
					d.si  = q.si + ONE;
					d.di  = q.di + ONE;
					d.cnt = q.cnt - ONE;
					if (q.cnt == ONE)
						d.st = ST_FETCH;
				end
			end
			OP_SKIP: begin
				if (s_out) begin
					d.st = ST_FILL;
					d.di = '0;
				end else begin
					if (!cv_zero)
						d.zero = 1'b0;
					d.si  = q.si + ONE;
					d.cnt = q.cnt - ONE;
					if (q.cnt == ONE)
						d.st = ST_FETCH;
				end
			end
			OP_INS: begin
				if (d_full) begin
					d.st = ST_FILL;
					d.di = '0;
				end else begin
					d.dst[q.di[3:0]] = q.tbl[q.fld[2:0]];
					d.di = q.di + ONE;
					d.st = ST_FETCH;
				end
			end
			OP_LTE, OP_CHT: begin
				if (m_out) begin
					d.ists[IRQ_FAULT] = 1'b1;
					d.st = ST_IDLE;
				end else begin
					if (q.op == OP_LTE)
						d.tbl[q.fld[2:0]] = m_ch;
					else
						d.tbl[3'(TBL_N - q.cnt)] = m_ch;
					d.mi  = q.mi + ONE;
					d.cnt = q.cnt - ONE;
					if (q.op == OP_LTE || q.cnt == ONE)
						d.st = ST_FETCH;
				end
			end
			OP_SES: begin
				d.es = 1'b1;
				if (q.fld[0])
					d.bz = 1'b1;
				d.st = ST_FETCH;
			end
			OP_ENF: begin
				d.es = 1'b1;
				d.bz = 1'b1;
				d.st = ST_FETCH;
			end
			endcase
		end
		ST_FILL: begin
			if (!(q.zero && q.bz) || d_full) begin
				if (!(q.zero && q.bz))
					d.di = q.dlen;
				d.ists[IRQ_DONE] = 1'b1;
				d.st = ST_IDLE;
			end else begin
				d.dst[q.di[3:0]] = q.tbl[0];
				d.di = q.di + ONE;
			end
		end
		default: d.st = ST_IDLE;
		endcase
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q     <= '0;
			q.tbl <= TBL_INIT;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	always_comb begin
		avs_waitrequest = (avs_read || avs_write) && !q.ack;
		avs_readdata    = q.rdata;
		busy            = q.st != ST_IDLE;
		irq             = |(q.ists & q.mask);
	end

endmodule

/* dv/edm_monitor.sv */
/*
 * bus and status checker for the edit micro-op engine.
 * assumes it sees only the engine ports, bound in below.
 */
`timescale 1ns/1ps
module edm_monitor (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   rst_b,
	// avalon-mm slave
	input wire logic [edm_pkg::AW-1:0] avs_address,
	input wire logic                   avs_read,
	input wire logic                   avs_write,
	input wire logic [31:0]            avs_writedata,
	input wire logic [31:0]            avs_readdata,
	input wire logic                   avs_waitrequest,
	// status
	input wire logic                   irq,
	input wire logic                   busy
);
	import edm_pkg::*;
	// ****************************************************************
	// properties
	// ****************************************************************
	logic rq;
	logic acc;
	assign rq = avs_read | avs_write;
	assign acc = rq & !avs_waitrequest;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_wait_one;
		$rose(rq) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
	property p_wait_idle;
		!rq |-> !avs_waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("wait when idle");
	property p_busy_cause;
		$rose(busy) |-> $past(acc && avs_write &&
			avs_address == REG_CTRL && avs_writedata[0]);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy no start");
	property p_busy_bound;
		$rose(busy) |-> ##[1:200] !busy;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("edit too long");
	// read data must stand between accesses
	property p_rd_hold;
		!rq && !$past(rq) |-> $stable(avs_readdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
	property p_ctrl_rd;
		acc && avs_read && avs_address == REG_CTRL |-> !avs_readdata[0];
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("start bit reads 1");
	property p_unmap;
		acc && avs_read && avs_address inside {8'h14, 8'h18, 8'h1C}
			|-> avs_readdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped not 0");
	property p_stat_busy;
		acc && avs_read && avs_address == REG_STAT
			|-> avs_readdata[0] == $past(busy);
	endproperty
	a_stat_busy: assert property (p_stat_busy) else $error("status busy");
	property p_mask_off;
		acc && avs_write && avs_address == REG_MASK &&
			avs_writedata[1:0] == 2'b00 |=> !irq;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq not masked");
endmodule
bind edm_engine edm_monitor i_mon (.clk(clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.irq(irq), .busy(busy));

/* dv/edm_host.sv */
/*
 * avalon-mm master standing in for the sequencer and operand fetch.
 * assumes one clock; one request at a time, held until accepted.
 */
`timescale 1ns/1ps
module edm_host (
	// clock
	input  wire logic        clk,
	// avalon-mm master
	output logic [7:0]       avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	initial begin
		avs_address = 8'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end
	// waitrequest and readdata are read at the rising edge, before that
	// edge's own register updates land, so the answer is the settled one
	task automatic req(input logic [7:0] a, input logic w,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// released lines show no stale value
		avs_address <= ~a;
		avs_writedata <= ~d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		req(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		req(a, 1'b0, 32'h0, q);
	endtask
endmodule

/* dv/test_edit_micro_op_engine.sv */
/*
 * self-checking bench of the edit micro-op engine.
 * assumes the host model drives the bus and the checker is bound.
 */
`timescale 1ns/1ps
module test_edit_micro_op_engine;
	import edm_pkg::*;
	logic          clk;
	logic          rst_b;
	logic [AW-1:0] avs_address;
	logic          avs_read;
	logic          avs_write;
	logic [31:0]   avs_writedata;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic          irq;
	logic          busy;
	int            error_cnt;
	int            samples_checked;
	logic [8:0]    exp_tbl [8] = '{9'h020, 9'h02A, 9'h02B, 9'h02D,
		9'h024, 9'h02C, 9'h02E, 9'h030};
	logic [31:0]   st;
	logic [31:0]   rv;
	logic [8:0]    ops [$];
	logic [8:0]    src [$];
	logic [8:0]    ch [8];
	logic [8:0]    v;
	logic [3:0]    d;
	logic [2:0]    ix;
	edm_engine i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq), .busy(busy));
	edm_host i_host (.clk(clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	// ****************************************************************
	// helpers
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] ln(input logic [4:0] o, s, t);
		return {11'h0, t, 3'h0, s, 3'h0, o};
	endfunction
	function automatic logic [31:0] asc(input logic [3:0] x);
		return 32'h30 + {28'h0, x};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
			input logic [31:0] e);
		i_host.rd(a, rv);
		chk(n, e, rv);
	endtask
	task automatic dst(input int i, input logic [31:0] e);
		rdc("dest", 8'(8'hC0 + 4 * i), e);
	endtask
	task automatic chk_tbl();
		for (int i = 0; i < 8; i++)
			rdc("table", 8'(8'h20 + 4 * i), {23'h0, exp_tbl[i]});
	endtask
	task automatic chk_irq(input logic e);
		@(negedge clk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	// polling keeps the wait tied to the engine's own busy bit
	task automatic run(input logic [31:0] ctl, len);
		foreach (ops[i]) i_host.wr(8'(8'h40 + 4 * i), {23'h0, ops[i]});
		foreach (src[i]) i_host.wr(8'(8'h80 + 4 * i), {23'h0, src[i]});
		i_host.wr(REG_LEN, len);
		i_host.wr(REG_CTRL, ctl | 32'h1);
		do i_host.rd(REG_STAT, st); while (st[0] !== 1'b0);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		close_out();
	end
	initial begin
		error_cnt = 0;
		samples_checked = 0;
		rst_b = 1'b0;
		void'($urandom(32'h7bfa));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		chk_tbl();
		rdc("status", REG_STAT, 32'h0);
		rdc("unmapped", 8'h14, 32'h0);
		$display("test reset done");
		ops = '{9'h004};
		repeat (4) src.push_back(9'(8'h20 + $urandom % 95));
		run(32'h0, ln(5'h1, 5'h4, 5'h3));
		for (int i = 0; i < 3; i++) dst(i, {23'h0, src[i]});
		dst(3, 32'h0);
		chk("count", 32'h3, {27'h0, st[12:8]});
		chk("neg", 32'h0, {31'h0, st[2]});
		$display("test alpha done");
		ix = 3'($urandom);
		v = 9'($urandom);
		ops = '{9'h100};
		foreach (ch[i]) begin
			ch[i] = 9'($urandom);
			ops.push_back(ch[i]);
		end
		ops.push_back({6'h18, ix});
		ops.push_back(v);
		ops.push_back({6'h10, ix});
		ops.push_back(9'h087);
		run(32'h0, ln(5'hD, 5'h1, 5'h2));
		dst(0, {23'h0, v});
		dst(1, {23'h0, ix == 3'h7 ? v : ch[7]});
		rdc("entry", 8'(8'h20 + 4 * ix), {23'h0, v});
		$display("test table done");
		ops = '{9'h001};
		src = '{9'h02D, 9'h02D, 9'h02D};
		for (int s = 0; s < 4; s++) begin
			run(32'(2 + 4 * s), ln(5'h1, 5'h3, 5'h1));
			chk("sign", {31'h0, s != 3}, {31'h0, st[2]});
		end
		chk_tbl();
		$display("test sign done");
		ops = '{9'h180, 9'h003};
		src = '{9'h02D, 9'h030, 9'h030, 9'h030};
		run(32'h6, ln(5'h2, 5'h4, 5'h3));
		chk("flags", 32'hF, {28'h0, st[4:1]});
		for (int i = 0; i < 3; i++) dst(i, 32'h20);
		d = 4'(1 + $urandom % 9);
		ops = '{9'h140, 9'h003};
		src = '{9'h000, {5'h0, d}, 9'h000};
		run(32'h9E, ln(5'h2, 5'h3, 5'h3));
		chk("flags", 32'h1, {28'h0, st[4:1]});
		dst(1, asc(d));
		dst(2, asc(4'h0));
		$display("test numeric done");
		d = 4'($urandom % 10);
		ops = '{9'h001};
		src = '{{5'h0, d}};
		run(32'h40, ln(5'h1, 5'h1, 5'h1));
		dst(0, asc(d));
		$display("test convert done");
		d = 4'(1 + $urandom % 9);
		ops = '{9'h1C1, 9'h043};
		src = '{9'h000, 9'h000, {5'h0, d}, 9'h00D};
		run(32'h1A, ln(5'h2, 5'h4, 5'h2));
		chk("flags", 32'h2, {28'h0, st[4:1]});
		chk("count", 32'h2, {27'h0, st[12:8]});
		dst(0, 32'h20);
		dst(1, asc(d));
		$display("test suppress done");
		i_host.wr(REG_IRQ, 32'h3);
		i_host.wr(REG_MASK, 32'h3);
		ops = '{9'h0C0};
		run(32'h0, ln(5'h1, 5'h1, 5'h1));
		rdc("irq status", REG_IRQ, 32'h2);
		chk_irq(1'b1);
		i_host.wr(REG_MASK, 32'h1);
		chk_irq(1'b0);
		i_host.wr(REG_MASK, 32'h3);
		chk_irq(1'b1);
		i_host.wr(REG_IRQ, 32'h2);
		chk_irq(1'b0);
		i_host.wr(REG_CTRL, 32'h301);
		rdc("type fault", REG_IRQ, 32'h2);
		chk_irq(1'b1);
		$display("test fault done");
		close_out();
	end
endmodule
